// ==== core/pcs_ms_tick.sv ====
// Millisecond tick divider
`default_nettype none
module pcs_ms_tick
  import pcs_pkg::*;
#(
  parameter int DIV = MS_CYC
)
(
  input wire logic clk,
  input wire logic srst,
  output logic tick
);
  logic [31:0] cnt_reg;
  always_ff @(posedge clk)
  begin
    if (srst || tick)
      cnt_reg <= 32'h0;
    else
      cnt_reg <= cnt_reg + 32'h1;
  end
  assign tick = (cnt_reg == 32'(DIV - 1));
endmodule
`default_nettype wire

// ==== core/pcs_sequencer.sv ====
// Top: start-up configuration sequencer with register port
`default_nettype none
module pcs_sequencer
  import pcs_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int TICK_DIV = MS_CYC
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic enable_pin,
  input wire logic [4:0] voltage_select_pin,
  input wire logic [4:0] address_select_pin,
  input wire logic [4:0] softstart_select_pin,
  input wire logic nvm_valid,
  input wire logic [9:0] nvm_vout,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic ready,
  output logic ramping,
  output logic output_on,
  output logic [9:0] vout_target,
  output logic [4:0] phase_offset,
  output logic [6:0] bus_address
);
  pcs_cfg_if cfg ();
  pcs_state_t state_reg;
  logic en_s1_reg, en_s2_reg;
  logic [4:0] vs1_reg, vs2_reg, as1_reg, as2_reg, ss1_reg, ss2_reg;
  logic [31:0] init_cnt_reg;
  logic [4:0] ms_cnt_reg;
  logic tick;
  logic restore_req_reg;
  logic start_reg;
  logic phase_ovr_reg;
  logic [4:0] phase_bus_reg;
  logic [9:0] vout_reg;
  logic [4:0] delay_prog_reg;
  logic [2:0] mode_reg;
  logic nvm_used_reg;
  logic [4:0] min_delay;
  logic [4:0] wait_ms;
  logic bus_ok;

  // Write strobe decode shared by the per-register processes
  function automatic logic wr_hit(input logic w, input logic ok, input logic [3:0] a,
    input logic [3:0] sel);
    return w && ok && (a == sel);
  endfunction

  // Mode bits decide the shortest legal pre-ramp wait
  function automatic logic [4:0] min_delay_of(input logic [2:0] m);
    if (m[MODE_SHARE_BIT] && (m[MODE_ACOMP_BIT] || m[MODE_STBY_BIT]))
      return 5'(MIN_DLY_SHARE_MS);
    else if (m[MODE_STBY_BIT])
      return 5'(MIN_DLY_STBY_MS);
    else
      return 5'(MIN_DLY_NORM_MS);
  endfunction

  pcs_ms_tick #(.DIV(TICK_DIV)) u_tick (.clk(clk), .srst(srst), .tick(tick));
  pcs_strap_loader u_load (
    .clk(clk),
    .srst(srst),
    .vsel_code(vs2_reg),
    .addr_code(as2_reg),
    .ss_code(ss2_reg),
    .cfg(cfg)
  );
  assign cfg.start = start_reg;

  // Pins cross from the analog side: two stages before use
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      vs1_reg <= STRAP_OPEN;
      vs2_reg <= STRAP_OPEN;
      as1_reg <= STRAP_OPEN;
      as2_reg <= STRAP_OPEN;
      ss1_reg <= STRAP_OPEN;
      ss2_reg <= STRAP_OPEN;
    end
    else
    begin
      en_s1_reg <= enable_pin;
      en_s2_reg <= en_s1_reg;
      vs1_reg <= voltage_select_pin;
      vs2_reg <= vs1_reg;
      as1_reg <= address_select_pin;
      as2_reg <= as1_reg;
      ss1_reg <= softstart_select_pin;
      ss2_reg <= ss1_reg;
    end
  end

  assign bus_ok = (state_reg != PCS_INIT) && (state_reg != PCS_LOAD);

  always_comb
  begin
    min_delay = min_delay_of(mode_reg);
    wait_ms = (delay_prog_reg < min_delay) ? min_delay : delay_prog_reg;
  end

  // Sequence
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= PCS_INIT;
      init_cnt_reg <= 32'h0;
      ms_cnt_reg <= 5'h00;
      start_reg <= 1'b0;
    end
    else
    begin
      start_reg <= 1'b0;
      unique case (state_reg)
        PCS_INIT:
        begin
          init_cnt_reg <= init_cnt_reg + 32'h1;
          if (init_cnt_reg >= 32'(INIT_CYCLES - 1))
          begin
            state_reg <= PCS_LOAD;
            start_reg <= 1'b1;
          end
        end
        PCS_LOAD:
          if (cfg.done)
            state_reg <= PCS_READY;
        PCS_READY:
          if (en_s2_reg)
          begin
            state_reg <= PCS_DELAY;
            ms_cnt_reg <= 5'h00;
          end
        PCS_DELAY:
          // Divider runs free, so the first counted millisecond may be anything from one clock to a full divider period
          if (!en_s2_reg)
            state_reg <= PCS_READY;
          else if (tick)
          begin
            ms_cnt_reg <= ms_cnt_reg + 5'h01;
            if (ms_cnt_reg + 5'h01 >= wait_ms)
            begin
              state_reg <= PCS_RAMP;
              ms_cnt_reg <= 5'h00;
            end
          end
        PCS_RAMP:
          if (!en_s2_reg)
            state_reg <= PCS_READY;
          else if (tick)
          begin
            ms_cnt_reg <= ms_cnt_reg + 5'h01;
            if (ms_cnt_reg + 5'h01 >= {1'b0, cfg.ramp_ms})
              state_reg <= PCS_ON;
          end
        PCS_ON:
          if (!en_s2_reg)
            state_reg <= PCS_READY;
      endcase
      // Restore reruns the whole check and load
      if (restore_req_reg)
      begin
        state_reg <= PCS_INIT;
        init_cnt_reg <= 32'h0;
      end
    end
  end

  // Software-written settings
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase_bus_reg <= 5'h00;
      vout_reg <= 10'd150;
      delay_prog_reg <= 5'h05;
    end
    else
    begin
      if (cfg.done)
      begin
        // Stored setpoint when the memory is valid, else the strap value; delay always from the straps
        vout_reg <= nvm_valid ? nvm_vout : cfg.vout;
        delay_prog_reg <= cfg.delay_ms;
      end
      else if (wr && bus_ok)
      begin
        unique case (addr)
          REG_VOUT:
            // Out of range words are dropped rather than clipped
            if (wdata[9:0] >= VOUT_MIN && wdata[9:0] <= VOUT_RANGE_TOP)
              vout_reg <= (wdata[9:0] > cfg.ceiling) ? cfg.ceiling : wdata[9:0];
          REG_PHASE:
            if (wdata[4:0] <= PHASE_STEPS_MAX)
              phase_bus_reg <= wdata[4:0];
          REG_DELAY:
            delay_prog_reg <= wdata[4:0];
          default:
            ;
        endcase
      end
    end
  end

  // One-cycle request; the sequence block turns it into a jump back to the memory check
  always_ff @(posedge clk)
  begin
    if (srst)
      restore_req_reg <= 1'b0;
    else
      restore_req_reg <= wr_hit(wr, bus_ok, addr, REG_CTRL) && wdata[CTRL_RESTORE_BIT];
  end

  // A fresh load always falls back to the address-derived phase
  always_ff @(posedge clk)
  begin
    if (srst)
      phase_ovr_reg <= 1'b0;
    else if (cfg.done)
      phase_ovr_reg <= 1'b0;
    else if (wr_hit(wr, bus_ok, addr, REG_CTRL))
      phase_ovr_reg <= wdata[CTRL_PHASE_OVR_BIT];
  end

  // Mode survives a restore: it is software state, not strap state
  always_ff @(posedge clk)
  begin
    if (srst)
      mode_reg <= 3'h0;
    else if (wr_hit(wr, bus_ok, addr, REG_MODE))
      mode_reg <= wdata[2:0];
  end

  // Latched with the load strobe so software can tell where the setpoint came from
  always_ff @(posedge clk)
  begin
    if (srst)
      nvm_used_reg <= 1'b0;
    else if (start_reg)
      nvm_used_reg <= nvm_valid;
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= 16'h0000;
    else if (rd && bus_ok)
      unique case (addr)
        REG_CTRL: rdata <= {14'h0, phase_ovr_reg, 1'b0};
        REG_STATUS: rdata <= {13'h0, state_reg};
        REG_VOUT: rdata <= {6'h0, vout_reg};
        REG_PHASE: rdata <= {11'h0, phase_offset};
        REG_DELAY: rdata <= {11'h0, delay_prog_reg};
        REG_MODE: rdata <= {13'h0, mode_reg};
        REG_CEIL: rdata <= {6'h0, cfg.ceiling};
        REG_NVM: rdata <= {15'h0, nvm_used_reg};
        default: rdata <= 16'h0000;
      endcase
    else
      rdata <= 16'h0000;
  end

  assign phase_offset = phase_ovr_reg ? phase_bus_reg : cfg.phase;
  assign ready = bus_ok;
  assign ramping = (state_reg == PCS_RAMP);
  assign output_on = (state_reg == PCS_ON);
  assign vout_target = vout_reg;
  assign bus_address = cfg.addr;
endmodule
`default_nettype wire

// ==== core/pcs_strap_loader.sv ====
// Strap loader: samples and decodes the multi-mode strap codes
`default_nettype none
module pcs_strap_loader
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] vsel_code,
  input wire logic [4:0] addr_code,
  input wire logic [4:0] ss_code,
  pcs_cfg_if.loader cfg
);
  logic [9:0] v;
  logic [6:0] a;
  always_comb
  begin
    v = pcs_vsel_decode(vsel_code);
    // Address: low/open/high give 0x23..0x25, resistors give 0x50 upward
    if (addr_code <= STRAP_HIGH)
      a = 7'h23 + {5'h00, addr_code[1:0]};
    else
      a = 7'h50 + {2'h0, addr_code - 5'h03};
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg.done <= 1'b0;
      cfg.vout <= 10'd150;
      cfg.ceiling <= 10'd165;
      cfg.addr <= 7'h24;
      cfg.phase <= 5'h00;
      cfg.ramp_ms <= 4'h5;
      cfg.delay_ms <= 5'h05;
    end
    else
    begin
      cfg.done <= cfg.start;
      if (cfg.start)
      begin
        cfg.vout <= v;
        cfg.ceiling <= v + (v / 10'd10);
        cfg.addr <= a;
        // Two 22.5 degree steps per address step, low three bits only
        cfg.phase <= {1'b0, a[2:0], 1'b0};
        cfg.ramp_ms <= (ss_code == STRAP_HIGH) ? 4'ha :
                       (ss_code == STRAP_LOW) ? 4'h2 : 4'h5;
        cfg.delay_ms <= (ss_code == STRAP_HIGH) ? 5'h0a : 5'h05;
      end
    end
  end
endmodule
`default_nettype wire

// ==== include/pcs_cfg_if.sv ====
// Interface: configuration results passed from the strap loader
`default_nettype none
interface pcs_cfg_if;
  logic start;
  logic done;
  logic [9:0] vout;
  logic [9:0] ceiling;
  logic [6:0] addr;
  logic [4:0] phase;
  logic [3:0] ramp_ms;
  logic [4:0] delay_ms;
  modport loader (input start, output done, vout, ceiling, addr, phase, ramp_ms, delay_ms);
  modport user (output start, input done, vout, ceiling, addr, phase, ramp_ms, delay_ms);
endinterface
`default_nettype wire

// ==== include/pcs_pkg.sv ====
// Package: constants and types of the power-up configuration sequencer
`default_nettype none
package pcs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  // Times in milliseconds, INIT_CYC in clock cycles
  localparam int INIT_MS = 5;
  localparam int INIT_CYC = INIT_MS * MS_CYC;
  localparam int MIN_DLY_NORM_MS = 5;
  localparam int MIN_DLY_STBY_MS = 10;
  localparam int MIN_DLY_SHARE_MS = 15;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_VOUT = 4'h2;
  localparam logic [3:0] REG_PHASE = 4'h3;
  localparam logic [3:0] REG_DELAY = 4'h4;
  localparam logic [3:0] REG_MODE = 4'h5;
  localparam logic [3:0] REG_CEIL = 4'h6;
  localparam logic [3:0] REG_NVM = 4'h7;
  // Control register fields
  localparam int CTRL_RESTORE_BIT = 0;
  localparam int CTRL_PHASE_OVR_BIT = 1;
  // Mode register fields
  localparam int MODE_SHARE_BIT = 0;
  localparam int MODE_ACOMP_BIT = 1;
  localparam int MODE_STBY_BIT = 2;
  // Setpoint in 10 mV units
  localparam logic [9:0] VOUT_MIN = 10'd60;
  localparam logic [9:0] VOUT_RANGE_TOP = 10'd360;
  // Phase offset in 22.5 degree steps, 0..16
  localparam logic [4:0] PHASE_STEPS_MAX = 5'h10;
  // Strap codes: 0 low, 1 open, 2 high, 3..31 resistor index
  localparam logic [4:0] STRAP_LOW = 5'h00;
  localparam logic [4:0] STRAP_OPEN = 5'h01;
  localparam logic [4:0] STRAP_HIGH = 5'h02;
  typedef enum logic [2:0] {PCS_INIT, PCS_LOAD, PCS_READY, PCS_DELAY, PCS_RAMP, PCS_ON} pcs_state_t;
  function automatic logic [9:0] pcs_vsel_decode(input logic [4:0] code);
    logic [9:0] v;
    v = 10'd150;
    case (code)
      5'd0: v = 10'd120;
      5'd1: v = 10'd150;
      5'd2: v = 10'd330;
      5'd3: v = 10'd60;
      5'd4: v = 10'd65;
      5'd5: v = 10'd70;
      5'd6: v = 10'd75;
      5'd7: v = 10'd80;
      5'd8: v = 10'd85;
      5'd9: v = 10'd90;
      5'd10: v = 10'd95;
      5'd11: v = 10'd100;
      5'd12: v = 10'd105;
      5'd13: v = 10'd110;
      5'd14: v = 10'd115;
      5'd15: v = 10'd120;
      5'd16: v = 10'd125;
      5'd17: v = 10'd130;
      5'd18: v = 10'd140;
      5'd19: v = 10'd150;
      5'd20: v = 10'd160;
      5'd21: v = 10'd170;
      5'd22: v = 10'd180;
      5'd23: v = 10'd190;
      5'd24: v = 10'd200;
      5'd25: v = 10'd210;
      5'd26: v = 10'd220;
      5'd27: v = 10'd230;
      5'd28: v = 10'd250;
      5'd29: v = 10'd280;
      5'd30: v = 10'd300;
      5'd31: v = 10'd360;
      default: v = 10'd150;
    endcase
    return v;
  endfunction
endpackage
`default_nettype wire

// ==== verif/pcs_sequencer_sva.sv ====
// Checker: timing and value relations at the sequencer ports
`default_nettype none
module pcs_sequencer_sva
  import pcs_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic ready,
  input wire logic ramping,
  input wire logic output_on,
  input wire logic [9:0] vout_target,
  input wire logic [4:0] phase_offset
);
  timeunit 1ns;
  timeprecision 100ps;
  int up_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Saturates so the start-up window is judged once per reset
  always_ff @(posedge clk)
  begin
    if (srst)
      up_cnt <= 0;
    else if (up_cnt < INIT_CYCLES + 20)
      up_cnt <= up_cnt + 1;
  end
  a_rdata_quiet: assert property (!$past(rd && ready) |-> rdata == 16'h0)
    else $error("read data outside an accepted read");
  a_ramp_ready: assert property (ramping || output_on |-> ready)
    else $error("ramp or output on without ready");
  a_init_quiet: assert property (up_cnt < INIT_CYCLES |-> !ready && !ramping)
    else $error("ready or ramp during memory check");
  a_ready_time: assert property (up_cnt == INIT_CYCLES + 10 |-> ready)
    else $error("ready late after start-up");
  a_enable_ignored: assert property (!ready |=> !ramping && !output_on)
    else $error("enable honoured while loading");
  a_delay_min: assert property ($rose(ramping) |-> $past(ready, 80))
    else $error("ramp started before minimum delay");
  a_ramp_first: assert property ($rose(output_on) |-> $past(ramping) && $past(ramping, 20))
    else $error("output on without a full ramp");
  a_vout_range: assert property (ready |-> vout_target inside {[VOUT_MIN:VOUT_RANGE_TOP]})
    else $error("setpoint out of range");
  a_phase_max: assert property (phase_offset <= PHASE_STEPS_MAX)
    else $error("phase offset above full turn");
endmodule
bind pcs_sequencer pcs_sequencer_sva #(.INIT_CYCLES(INIT_CYCLES)) i_sva (.clk(clk), .srst(srst),
  .rd(rd), .rdata(rdata), .ready(ready), .ramping(ramping), .output_on(output_on),
  .vout_target(vout_target), .phase_offset(phase_offset));
`default_nettype wire

// ==== verif/pcs_sequencer_test.sv ====
// Testbench: start-up, strap decode, bus limits and pre-ramp timing
`default_nettype none
module pcs_sequencer_test
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int INIT_N = 50;
  localparam int TK = 20;
  // Setpoints in 10 mV units by strap code; top code is the 162k end
  localparam logic [9:0] VT [32] = '{120, 150, 330, 60, 65, 70, 75, 80, 85, 90, 95, 100, 105,
    110, 115, 120, 125, 130, 140, 150, 160, 170, 180, 190, 200, 210, 220, 230, 250, 280, 300, 360};
  localparam int WV [6] = '{100, 59, 61, 361, 361, 360};
  localparam int WE [6] = '{66, 66, 61, 61, 330, 360};
  localparam int M [5] = '{0, 4, 3, 1, 6};
  localparam int D [5] = '{2, 3, 1, 12, 4};
  localparam logic [4:0] S [5] = '{0, 2, 1, 5, 7};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic enable_pin = 1'b1;
  logic [4:0] vc = 5'h03;
  logic [4:0] ac = 5'h04;
  logic [4:0] sc = 5'h00;
  logic nv_ok = 1'b0;
  logic [9:0] nv_val = 10'h0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] v_pin, a_pin, s_pin, phase_offset;
  logic nvm_valid, ready, ramping, output_on;
  logic [9:0] nvm_vout, vout_target;
  logic [15:0] rdata, rv;
  logic [6:0] bus_address;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  pcs_strap_model i_straps (.clk(clk), .v_code(vc), .a_code(ac), .s_code(sc), .nv_ok(nv_ok),
    .nv_val(nv_val), .v_pin(v_pin), .a_pin(a_pin), .s_pin(s_pin), .nv_pin(nvm_valid),
    .nv_data(nvm_vout));
  pcs_sequencer #(.INIT_CYCLES(INIT_N), .TICK_DIV(TK)) i_dut (.clk(clk), .srst(srst),
    .enable_pin(enable_pin), .voltage_select_pin(v_pin), .address_select_pin(a_pin),
    .softstart_select_pin(s_pin), .nvm_valid(nvm_valid), .nvm_vout(nvm_vout), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ready(ready), .ramping(ramping),
    .output_on(output_on), .vout_target(vout_target), .phase_offset(phase_offset),
    .bus_address(bus_address));
  function automatic logic [6:0] a_exp(input logic [4:0] c);
    return (c < 5'd3) ? 7'h23 + 7'(c) : 7'h50 + 7'(c - 5'd3);
  endfunction
  function automatic int min_exp(input int m);
    return (m[MODE_SHARE_BIT] && (m[MODE_ACOMP_BIT] || m[MODE_STBY_BIT])) ? 15 :
      m[MODE_STBY_BIT] ? 10 : 5;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Bounded wait: 0 ready, 1 ramping, 2 output on
  task automatic wait_hi(input int w, output int n);
    n = 0;
    while (!(w == 0 ? ready === 1'b1 : w == 1 ? ramping === 1'b1 : output_on === 1'b1) && n < 900)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wait_limit", 16'(n < 900), 16'h1);
  endtask
  task automatic reload(input logic [4:0] v, input logic [4:0] a, input logic [4:0] s,
    input logic ok);
    int n;
    vc = v;
    ac = a;
    sc = s;
    nv_ok = ok;
    // Model register plus two synchroniser stages
    repeat (4) @(posedge clk);
    wreg(REG_CTRL, 16'h0001);
    // Request lands at the write edge, the jump back one edge later
    @(posedge clk);
    #1;
    chk("ready_drop", 16'(ready), 16'h0);
    wait_hi(0, n);
  endtask
  task automatic chk_cfg();
    logic [6:0] a;
    a = a_exp(ac);
    chk("vout", 16'(vout_target), 16'(nv_ok ? nv_val : VT[vc]));
    chk("address", 16'(bus_address), 16'(a));
    chk("phase", 16'(phase_offset), 16'({a[2:0], 1'b0}));
    rreg(REG_CEIL, rv);
    chk("ceiling", rv, 16'(VT[vc] + VT[vc] / 10));
    rreg(REG_STATUS, rv);
    chk("status", rv, 16'h2);
    rreg(REG_NVM, rv);
    chk("nvm_used", rv, 16'(nv_ok));
    rreg(REG_DELAY, rv);
    chk("strap_delay", rv, (sc == STRAP_HIGH) ? 16'h000a : 16'h0005);
  endtask
  initial
  begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    int n;
    void'($urandom(32'hc94e57bc));
    repeat (10) @(posedge clk);
    #1;
    chk("reset", {vout_target, 6'(ready)}, {10'd150, 6'h0});
    srst <= 1'b0;
    // Enable held high from power-up while the bus is poked
    wreg(REG_VOUT, 16'd300);
    rreg(REG_STATUS, rv);
    chk("busy_read", rv, 16'h0);
    wait_hi(1, n);
    chk("late_ramp", 16'(n + 4 >= INIT_N + 4 * TK), 16'h1);
    wait_hi(2, n);
    enable_pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk_cfg();
    $display("test startup done");
    wreg(REG_PHASE, 16'h0010);
    wreg(REG_CTRL, 16'h0002);
    chk("phase_ovr", 16'(phase_offset), 16'h10);
    wreg(REG_PHASE, 16'h0011);
    rreg(REG_PHASE, rv);
    chk("phase_drop", rv, 16'h10);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 4)
      begin
        reload(5'd2, 5'd0, 5'd2, 1'b0);
        chk_cfg();
      end
      wreg(REG_VOUT, 16'(WV[i]));
      chk("vout_write", 16'(vout_target), 16'(WE[i]));
    end
    $display("test bus limits done");
    for (int i = 0; i < 5; i++)
    begin
      logic [4:0] v;
      v = (i == 0) ? 5'd31 : 5'($urandom);
      nv_val = 10'd60 + 10'($urandom % (VT[v] - 10'd59));
      reload(v, 5'($urandom), 5'($urandom), 1'(i % 2));
      chk_cfg();
    end
    $display("test random straps done");
    for (int i = 0; i < 5; i++)
    begin
      int d;
      int r;
      reload(5'd3, 5'd4, S[i], 1'b0);
      wreg(REG_MODE, 16'(M[i]));
      wreg(REG_DELAY, 16'(D[i]));
      d = (D[i] > min_exp(M[i])) ? D[i] : min_exp(M[i]);
      r = (S[i] == STRAP_LOW) ? 2 : (S[i] == STRAP_HIGH) ? 10 : 5;
      enable_pin <= 1'b1;
      wait_hi(1, n);
      chk("delay", 16'(n >= (d - 1) * TK && n <= d * TK + 6), 16'h1);
      wait_hi(2, n);
      chk("ramp", 16'(n >= (r - 1) * TK && n <= r * TK + 2), 16'h1);
      enable_pin <= 1'b0;
      repeat (6) @(posedge clk);
    end
    $display("test ramp timing done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== verif/pcs_strap_model.sv ====
// Far-side model: strap resistors and stored configuration memory
`default_nettype none
module pcs_strap_model
(
  input wire logic clk,
  input wire logic [4:0] v_code,
  input wire logic [4:0] a_code,
  input wire logic [4:0] s_code,
  input wire logic nv_ok,
  input wire logic [9:0] nv_val,
  output logic [4:0] v_pin,
  output logic [4:0] a_pin,
  output logic [4:0] s_pin,
  output logic nv_pin,
  output logic [9:0] nv_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // Straps only move between loads; the sequencer's own clock paces them
  always @(posedge clk)
  begin
    v_pin <= v_code;
    a_pin <= a_code;
    s_pin <= s_code;
    nv_pin <= nv_ok;
    // Empty memory shows the inverse so a stale value cannot pass
    nv_data <= nv_ok ? nv_val : ~nv_val;
  end
endmodule
`default_nettype wire
